// >>> rtl/camera_gpio_line_control.sv
`timescale 1ns/1ps
// What this block does
// - Four lines, picked one at a time
// - Per-line input or output direction
// - Per-line inversion, both directions
// - Picked line readback: high reads one, or zero on an inverted input
// - Vector bit n shows line n
// - Vector sampled for all lines together
// - Output select acts only on outputs
// - Other-line source forms a loopback
// - Exposure source follows sensor exposing
// - Trigger-wait source follows trigger readiness
module camera_gpio_line_control
(
  input wire logic clk_i,
  input wire logic resetn_i,
  // AXI4-Lite write address
  input wire logic [gpio_line_pkg::ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic [2:0] s_axi_awprot_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  // AXI4-Lite read address
  input wire logic [gpio_line_pkg::ADDR_W-1:0] s_axi_araddr_i,
  input wire logic [2:0] s_axi_arprot_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // Connector lines, split three ways
  input wire logic [gpio_line_pkg::NUM_LINES-1:0] line_in_i,
  output logic [gpio_line_pkg::NUM_LINES-1:0] line_out_o,
  output logic [gpio_line_pkg::NUM_LINES-1:0] line_oe_o,
  // Internal camera signals, same clock
  input wire logic sensor_exposing_flag_i,
  input wire logic awaiting_frame_trigger_i,
  // Aux supply rail switch
  output logic aux_rail_enable_o
);
  import gpio_line_pkg::*;

  // ==========================================================
  // Declarations
  typedef enum logic [1:0]
  {
    WS_IDLE = 2'b01, // Collecting address and data
    WS_RESP = 2'b10 // Response offered
  } wr_state_t;

  wr_state_t wr_state_r; // Write channel state
  logic aw_have_r; // Write address held
  logic w_have_r; // Write data held
  logic [ADDR_W-1:0] aw_addr_r; // Held write address
  logic [31:0] w_data_r; // Held write data
  logic w_lane0_r; // Low byte lane enabled
  logic [1:0] bresp_r; // Write answer
  logic rvalid_r; // Read answer pending
  logic [31:0] rdata_r; // Read answer data
  logic [1:0] rresp_r; // Read answer code
  logic [PICK_W-1:0] line_pick_r; // Picked line
  line_cfg_vec_t cfg_r; // Per-line settings
  logic aux_req_r; // Software rail request
  logic aux_on_r; // Rail as switched
  logic [CNT_W-1:0] aux_cnt_r; // Settle counter
  logic [NUM_LINES-1:0] pin_level; // Synchronised pins
  logic [NUM_LINES-1:0] level_r; // Line levels, one sample
  logic do_write; // Address and data both held
  logic rd_take; // Read address taken
  logic [31:0] rd_word; // Word for the read address
  logic rd_err; // Read address unmapped
  logic wr_err; // Write address unmapped

  // Address decode, used by writes only; reads decode in the read word selection
  function automatic logic addr_known(input logic [ADDR_W-1:0] a);
    return (a == OFF_LINE_PICK) || (a == OFF_LINE_DIRECTION) ||
      (a == OFF_LINE_POLARITY_FLIP) || (a == OFF_LINE_LEVEL_READBACK) ||
      (a == OFF_ALL_LINES_LEVEL_VECTOR) ||
      (a == OFF_LINE_OUTPUT_SELECT) || (a == OFF_AUX_RAIL_ENABLE);
  endfunction : addr_known

  // ==========================================================
  // Bus handshakes
  assign s_axi_awready_o = !aw_have_r && (wr_state_r == WS_IDLE);
  assign s_axi_wready_o = !w_have_r && (wr_state_r == WS_IDLE);
  assign s_axi_bvalid_o = (wr_state_r == WS_RESP);
  assign s_axi_bresp_o = bresp_r;
  assign s_axi_arready_o = !rvalid_r;
  assign s_axi_rvalid_o = rvalid_r;
  assign s_axi_rdata_o = rdata_r;
  assign s_axi_rresp_o = rresp_r;
  assign do_write = aw_have_r && w_have_r && (wr_state_r == WS_IDLE);
  assign rd_take = s_axi_arvalid_i && !rvalid_r;
  assign wr_err = !addr_known(aw_addr_r);
  assign aux_rail_enable_o = aux_on_r;

  // ==========================================================
  // Write address and data capture, either order
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h0000_0000;
      w_lane0_r <= 1'b0;
    end
    else if (do_write)
    begin
      // Both consumed by the commit
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
    end
    else
    begin
      // Address taken
      if (s_axi_awvalid_i && s_axi_awready_o)
      begin
        aw_have_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr_i;
      end
      // Data taken
      if (s_axi_wvalid_i && s_axi_wready_o)
      begin
        w_have_r <= 1'b1;
        w_data_r <= s_axi_wdata_i;
        w_lane0_r <= s_axi_wstrb_i[0];
      end
    end
  end

  // ==========================================================
  // Write response state machine
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      wr_state_r <= WS_IDLE;
      bresp_r <= RESP_OKAY;
    end
    else
    begin
      case (wr_state_r)
        WS_IDLE:
        begin
          // Answer once both halves are in
          if (do_write)
          begin
            wr_state_r <= WS_RESP;
            bresp_r <= wr_err ? RESP_SLVERR : RESP_OKAY;
          end
        end
        WS_RESP:
        begin
          // Held until the master takes it
          if (s_axi_bready_i)
            wr_state_r <= WS_IDLE;
        end
        default:
          wr_state_r <= WS_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Line pick and per-line settings
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      line_pick_r <= RST_PICK;
      for (int n = 0; n < NUM_LINES; n++)
      begin
        cfg_r[n].line_direction <= DIR_INPUT;
        cfg_r[n].line_polarity_flip <= RST_FLIP;
        cfg_r[n].line_output_select <= SRC_OFF;
      end
    end
    else if (do_write && w_lane0_r)
    begin
      if (aw_addr_r == OFF_LINE_PICK)
        line_pick_r <= w_data_r[PICK_W-1:0];
      else if (aw_addr_r == OFF_LINE_DIRECTION)
        cfg_r[line_pick_r].line_direction <=
          line_dir_t'(w_data_r[FLD_BIT0]);
      else if (aw_addr_r == OFF_LINE_POLARITY_FLIP)
        cfg_r[line_pick_r].line_polarity_flip <= w_data_r[FLD_BIT0];
      else if (aw_addr_r == OFF_LINE_OUTPUT_SELECT)
        cfg_r[line_pick_r].line_output_select <=
          w_data_r[FLD_SEL_LSB +: SEL_W];
    end
  end

  // ==========================================================
  // Aux rail request and slow switch
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      aux_req_r <= RST_AUX;
      aux_on_r <= RST_AUX;
      aux_cnt_r <= 8'h00;
    end
    else
    begin
      if (do_write && w_lane0_r && aw_addr_r == OFF_AUX_RAIL_ENABLE)
        aux_req_r <= w_data_r[FLD_BIT0];
      if (aux_on_r == aux_req_r)
        aux_cnt_r <= 8'h00;
      else if (aux_cnt_r == CNT_W'(AUX_SETTLE_CYCLES - 1))
      begin
        aux_on_r <= aux_req_r;
        aux_cnt_r <= 8'h00;
      end
      else
        aux_cnt_r <= aux_cnt_r + 8'h01;
    end
  end

  // ==========================================================
  // Pin synchroniser
  line_sync u_sync
  (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .pin_i(line_in_i),
    .level_o(pin_level)
  );

  // ==========================================================
  // Line levels, all sampled in one cycle
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
      level_r <= 4'h0;
    else
    begin
      for (int n = 0; n < NUM_LINES; n++)
      begin
        if (cfg_r[n].line_direction == DIR_INPUT)
          level_r[n] <= pin_level[n] ^ cfg_r[n].line_polarity_flip;
        // Output reads back the pin itself
        else
          level_r[n] <= pin_level[n];
      end
    end
  end

  // ==========================================================
  // Pin drivers
  line_driver u_drv
  (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .cfg_i(cfg_r),
    .level_i(level_r),
    .sensor_exposing_flag_i(sensor_exposing_flag_i),
    .awaiting_frame_trigger_i(awaiting_frame_trigger_i),
    .line_out_o(line_out_o),
    .line_oe_o(line_oe_o)
  );

  // ==========================================================
  // Read word selection
  always_comb
  begin
    rd_word = 32'h0000_0000;
    rd_err = 1'b0;
    if (s_axi_araddr_i == OFF_LINE_PICK)
      rd_word[PICK_W-1:0] = line_pick_r;
    else if (s_axi_araddr_i == OFF_LINE_DIRECTION)
      rd_word[FLD_BIT0] = cfg_r[line_pick_r].line_direction;
    else if (s_axi_araddr_i == OFF_LINE_POLARITY_FLIP)
      rd_word[FLD_BIT0] = cfg_r[line_pick_r].line_polarity_flip;
    else if (s_axi_araddr_i == OFF_LINE_LEVEL_READBACK)
      rd_word[FLD_BIT0] = level_r[line_pick_r];
    else if (s_axi_araddr_i == OFF_ALL_LINES_LEVEL_VECTOR)
      rd_word[NUM_LINES-1:0] = level_r;
    else if (s_axi_araddr_i == OFF_LINE_OUTPUT_SELECT)
      rd_word[FLD_SEL_LSB +: SEL_W] =
        cfg_r[line_pick_r].line_output_select;
    else if (s_axi_araddr_i == OFF_AUX_RAIL_ENABLE)
      rd_word[FLD_BIT0] = aux_req_r;
    else
      rd_err = 1'b1;
  end

  // ==========================================================
  // Read answer register
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= RESP_OKAY;
    end
    else if (rd_take)
    begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_word;
      rresp_r <= rd_err ? RESP_SLVERR : RESP_OKAY;
    end
    else if (s_axi_rready_i)
      rvalid_r <= 1'b0;
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  sequence s_pick_write;
    do_write && w_lane0_r && aw_addr_r == OFF_LINE_PICK;
  endsequence

  sequence s_read_of(logic [7:0] a);
    rd_take && s_axi_araddr_i == a;
  endsequence

  property p_pick_stored;
    s_pick_write |=> line_pick_r == $past(w_data_r[1:0]);
  endproperty
  a_pick_stored: assert property (p_pick_stored)
    else $error("line pick not stored");

  property p_oe_follows_dir;
    ##1 line_oe_o[0] == ($past(cfg_r[0].line_direction) == DIR_OUTPUT);
  endproperty
  a_oe_follows_dir: assert property (p_oe_follows_dir)
    else $error("line 0 enable disagrees with direction");

  property p_input_inverted;
    (cfg_r[0].line_direction == DIR_INPUT &&
     cfg_r[0].line_polarity_flip && $stable(line_in_i[0]))[*4]
    |-> level_r[0] == !line_in_i[0];
  endproperty
  a_input_inverted: assert property (p_input_inverted)
    else $error("inverted input level wrong");

  property p_readback;
    s_read_of(OFF_LINE_LEVEL_READBACK) |=>
      rvalid_r && rdata_r[0] == $past(level_r[line_pick_r]);
  endproperty
  a_readback: assert property (p_readback)
    else $error("picked line readback wrong");

  property p_vector;
    s_read_of(OFF_ALL_LINES_LEVEL_VECTOR) |=>
      rdata_r == {28'h0000000, $past(level_r)};
  endproperty
  a_vector: assert property (p_vector)
    else $error("level vector not one sample");

  property p_loopback;
    cfg_r[1] == {DIR_OUTPUT, 1'b0, SRC_LINE0} |=>
      line_out_o[1] == $past(level_r[0]);
  endproperty
  a_loopback: assert property (p_loopback)
    else $error("loopback to line 1 wrong");

  property p_exposing;
    cfg_r[0] == {DIR_OUTPUT, 1'b0, SRC_EXPOSING} |=>
      line_out_o[0] == $past(sensor_exposing_flag_i);
  endproperty
  a_exposing: assert property (p_exposing)
    else $error("exposure source not driven");

  property p_trig_wait;
    cfg_r[0] == {DIR_OUTPUT, 1'b1, SRC_TRIG_WAIT} |=>
      line_out_o[0] == !$past(awaiting_frame_trigger_i);
  endproperty
  a_trig_wait: assert property (p_trig_wait)
    else $error("trigger wait source not driven");

  property p_aux_slow;
    $changed(aux_rail_enable_o) |->
      $past(aux_cnt_r) == CNT_W'(AUX_SETTLE_CYCLES - 1);
  endproperty
  a_aux_slow: assert property (p_aux_slow)
    else $error("aux rail switched early");

  property p_input_undriven;
    cfg_r[2].line_direction == DIR_INPUT |=>
      !line_oe_o[2] && !line_out_o[2];
  endproperty
  a_input_undriven: assert property (p_input_undriven)
    else $error("input line driven");

endmodule : camera_gpio_line_control

// >>> rtl/gpio_line_pkg.sv
// ==========================================================
// Shared constants and types for the GPIO line block
package gpio_line_pkg;

  // ==========================================================
  // Sizes
  localparam int NUM_LINES = 4; // Lines on the connector
  localparam int ADDR_W = 8; // Register byte address width
  localparam int SEL_W = 3; // Output select code width
  localparam int PICK_W = 2; // Line pick width

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] OFF_LINE_PICK = 8'h00; // Line pick, RW
  localparam logic [7:0] OFF_LINE_DIRECTION = 8'h04; // Picked dir, RW
  localparam logic [7:0] OFF_LINE_POLARITY_FLIP = 8'h08; // Picked flip
  localparam logic [7:0] OFF_LINE_LEVEL_READBACK = 8'h0C; // Picked, RO
  localparam logic [7:0] OFF_ALL_LINES_LEVEL_VECTOR = 8'h10; // RO
  localparam logic [7:0] OFF_LINE_OUTPUT_SELECT = 8'h14; // Picked src
  localparam logic [7:0] OFF_AUX_RAIL_ENABLE = 8'h18; // Rail, RW

  // ==========================================================
  // Field positions inside the data word
  localparam int FLD_BIT0 = 0; // Single-bit fields
  localparam int FLD_SEL_LSB = 0; // Output select low bit

  // ==========================================================
  // Bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0; // Normal answer
  localparam logic [1:0] RESP_SLVERR = 2'h2; // Unmapped address

  // ==========================================================
  // Output select codes
  localparam logic [2:0] SRC_OFF = 3'h0; // Drive low, or high when the line's polarity flip is set
  localparam logic [2:0] SRC_LINE0 = 3'h1; // Loop back line 0
  localparam logic [2:0] SRC_LINE3 = 3'h4; // Loop back line 3
  localparam logic [2:0] SRC_EXPOSING = 3'h5; // Sensor exposing
  localparam logic [2:0] SRC_TRIG_WAIT = 3'h6; // Awaiting trigger
  localparam logic [2:0] SRC_SERIAL0 = 3'h7; // No serial here, driven as SRC_OFF

  // ==========================================================
  // Reset values
  localparam logic [1:0] RST_PICK = 2'h0; // Line 0 picked
  localparam logic RST_DIR = 1'b0; // Every line an input
  localparam logic RST_FLIP = 1'b0; // No inversion
  localparam logic RST_AUX = 1'b0; // Rail off

  // ==========================================================
  // Timing of the slow rail switch
  localparam int CLK_PERIOD_NS = 10; // 100 MHz
  localparam int AUX_SETTLE_NS = 1000; // Least switch time
  localparam int AUX_SETTLE_CYCLES =
    (AUX_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 8; // Settle counter width

  // ==========================================================
  // Types
  typedef enum logic {DIR_INPUT = 1'b0, DIR_OUTPUT = 1'b1} line_dir_t;

  // Per-line configuration
  typedef struct packed {
    line_dir_t line_direction; // Input or output
    logic line_polarity_flip; // Invert the line
    logic [2:0] line_output_select; // Source when output
  } line_cfg_t;

  // All lines' configuration together
  typedef line_cfg_t [3:0] line_cfg_vec_t;

endpackage : gpio_line_pkg

// >>> rtl/line_driver.sv
`timescale 1ns/1ps
// ==========================================================
// Registered pin drivers for all lines
module line_driver
  import gpio_line_pkg::*;
(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire gpio_line_pkg::line_cfg_vec_t cfg_i,
  input wire logic [gpio_line_pkg::NUM_LINES-1:0] level_i,
  input wire logic sensor_exposing_flag_i,
  input wire logic awaiting_frame_trigger_i,
  output logic [gpio_line_pkg::NUM_LINES-1:0] line_out_o,
  output logic [gpio_line_pkg::NUM_LINES-1:0] line_oe_o
);
  // Driven values and enables
  logic [NUM_LINES-1:0] out_r;
  logic [NUM_LINES-1:0] oe_r;

  // Level of the chosen internal source
  function automatic logic src_level(input logic [2:0] sel,
    input logic [3:0] lvl, input logic expo, input logic trig);
    logic v;
    v = 1'b0;
    if (sel >= SRC_LINE0 && sel <= SRC_LINE3)
      v = lvl[2'(sel - SRC_LINE0)];
    else if (sel == SRC_EXPOSING)
      v = expo;
    else if (sel == SRC_TRIG_WAIT)
      v = trig;
    return v;
  endfunction : src_level

  // ==========================================================
  // Drive each line
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      out_r <= 4'h0;
      oe_r <= 4'h0;
    end
    else
    begin
      for (int n = 0; n < NUM_LINES; n++)
      begin
        oe_r[n] <= (cfg_i[n].line_direction == DIR_OUTPUT);
        out_r[n] <= (cfg_i[n].line_direction == DIR_OUTPUT) &&
          (src_level(cfg_i[n].line_output_select, level_i,
            sensor_exposing_flag_i, awaiting_frame_trigger_i) ^
           cfg_i[n].line_polarity_flip);
      end
    end
  end

  assign line_out_o = out_r;
  assign line_oe_o = oe_r;

endmodule : line_driver

// >>> rtl/line_sync.sv
`timescale 1ns/1ps
// ==========================================================
// Two-stage synchroniser for the connector pins
module line_sync
  import gpio_line_pkg::*;
(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [gpio_line_pkg::NUM_LINES-1:0] pin_i,
  output logic [gpio_line_pkg::NUM_LINES-1:0] level_o
);
  // First stage, read only by the second
  logic [NUM_LINES-1:0] meta_r;
  // Second stage
  logic [NUM_LINES-1:0] level_r;

  // ==========================================================
  // Both stages
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      meta_r <= 4'h0;
      level_r <= 4'h0;
    end
    else
    begin
      meta_r <= pin_i;
      level_r <= meta_r;
    end
  end

  assign level_o = level_r;

endmodule : line_sync

// >>> tb/camera_gpio_line_control_tb_top.sv
`timescale 1ns/1ps
// ==========================================================
// Bench for the GPIO line block
module camera_gpio_line_control_tb_top;
  import gpio_line_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0; // Active low reset
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata;
  logic awready, wready, bvalid, arready, rvalid, aux;
  logic [1:0] bresp, rresp;
  logic [3:0] pin, lout, loe;
  logic [3:0] ext = 4'h0; // Outside levels
  logic expo = 1'b0, trig = 1'b0;
  logic [3:0] wstrb = 4'hF; // Write byte lanes
  int errors = 0, tests_run = 0, cyc = 0;
  logic dir[4] = '{default: 1'b0}; // Model state
  logic flp[4] = '{default: 1'b0};
  logic [2:0] sel[4] = '{default: 3'h0};
  logic [7:0] seed = 8'h31;

  always #5 clk = ~clk;

  camera_gpio_line_control DUT (
    .clk_i(clk), .resetn_i(rstn),
    .s_axi_awaddr_i(awaddr), .s_axi_awprot_i(3'h0),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb),
    .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arprot_i(3'h0),
    .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .line_in_i(pin), .line_out_o(lout), .line_oe_o(loe),
    .sensor_exposing_flag_i(expo),
    .awaiting_frame_trigger_i(trig),
    .aux_rail_enable_o(aux)
  );

  gpio_pins_model pins (
    .line_out_i(lout), .line_oe_i(loe),
    .ext_level_i(ext), .line_in_o(pin)
  );

  // ==========================================================
  // Hang guard
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      errors++;
      results();
    end
  end

  // ==========================================================
  // Helpers
  task automatic results();
    if (errors == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : results

  task automatic chk(input string nm, input logic [31:0] s, e);
    tests_run++;
    if (s !== e)
    begin
      errors++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : lfsr

  // Bus write, both channels offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] er);
    logic aw_open, w_open, b_open;
    aw_open = 1'b1;
    w_open = 1'b1;
    b_open = 1'b1;
    // One edge apart, so no signal is set twice in a step
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (b_open)
    begin
      @(posedge clk);
      // Each channel released at its own handshake edge
      if (aw_open && awready)
      begin
        awvalid <= 1'b0;
        aw_open = 1'b0;
      end
      if (w_open && wready)
      begin
        wvalid <= 1'b0;
        w_open = 1'b0;
      end
      if (bvalid)
      begin
        bready <= 1'b0;
        b_open = 1'b0;
        chk("bresp", 32'(bresp), 32'(er));
      end
    end
  endtask : wr

  // Bus read
  task automatic rd(input logic [7:0] a, input logic [1:0] er,
    output logic [31:0] d);
    logic ar_open, r_open;
    ar_open = 1'b1;
    r_open = 1'b1;
    // One edge apart, so no signal is set twice in a step
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (r_open)
    begin
      @(posedge clk);
      // Address released at its handshake edge
      if (ar_open && arready)
      begin
        arvalid <= 1'b0;
        ar_open = 1'b0;
      end
      if (rvalid)
      begin
        rready <= 1'b0;
        r_open = 1'b0;
        d = rdata;
        chk("rresp", 32'(rresp), 32'(er));
      end
    end
  endtask : rd

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, RESP_OKAY, d);
    chk($sformatf("reg %h", a), d, e);
  endtask : rc

  // Expected levels and outputs; loopback only from lower lines
  task automatic model(output logic [3:0] lv, ov);
    logic p;
    for (int k = 0; k < 4; k++)
    begin
      case (sel[k])
        3'h0, 3'h7: ov[k] = 1'b0;
        3'h5: ov[k] = expo;
        3'h6: ov[k] = trig;
        default: ov[k] = lv[sel[k] - 3'h1];
      endcase
      ov[k] = ov[k] ^ flp[k];
      p = dir[k] ? ov[k] : ext[k];
      lv[k] = dir[k] ? p : p ^ flp[k];
    end
  endtask : model

  // ==========================================================
  // Main sequence
  initial
  begin
    logic [3:0] lv, ov, dv;
    logic [31:0] d;
    logic [2:0] s;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    // Reset state
    rc(OFF_LINE_PICK, 32'h0);
    rc(OFF_LINE_DIRECTION, 32'h0);
    rc(OFF_LINE_POLARITY_FLIP, 32'h0);
    rc(OFF_LINE_LEVEL_READBACK, 32'h0);
    rc(OFF_ALL_LINES_LEVEL_VECTOR, 32'h0);
    rc(OFF_LINE_OUTPUT_SELECT, 32'h0);
    rc(OFF_AUX_RAIL_ENABLE, 32'h0);
    chk("line_oe", 32'(loe), 32'h0);
    rd(8'h1C, RESP_SLVERR, d);
    chk("unmapped", d, 32'h0);
    wr(8'h1C, 32'h1, RESP_SLVERR);
    wr(OFF_ALL_LINES_LEVEL_VECTOR, 32'hF, RESP_OKAY);
    // Random configurations of all lines
    repeat (10)
    begin
      for (int k = 0; k < 4; k++)
      begin
        seed = lfsr(seed);
        s = seed[2:0];
        if (s >= 3'h1 && s <= 3'h4)
          s = (k == 0) ? SRC_EXPOSING : 3'(1 + (s - 1) % k);
        dir[k] = seed[3];
        flp[k] = seed[4];
        sel[k] = s;
        wr(OFF_LINE_PICK, 32'(k), RESP_OKAY);
        wr(OFF_LINE_DIRECTION, 32'(dir[k]), RESP_OKAY);
        wr(OFF_LINE_POLARITY_FLIP, 32'(flp[k]), RESP_OKAY);
        wr(OFF_LINE_OUTPUT_SELECT, 32'(s), RESP_OKAY);
      end
      seed = lfsr(seed);
      ext <= seed[3:0];
      expo <= seed[4];
      trig <= seed[6];
      repeat (30) @(posedge clk);
      model(lv, ov);
      for (int k = 0; k < 4; k++) dv[k] = dir[k];
      chk("line_oe", 32'(loe), 32'(dv));
      chk("line_out", 32'(lout & dv), 32'(ov & dv));
      rc(OFF_ALL_LINES_LEVEL_VECTOR, 32'(lv));
      for (int k = 0; k < 4; k++)
      begin
        wr(OFF_LINE_PICK, 32'(k), RESP_OKAY);
        rc(OFF_LINE_LEVEL_READBACK, 32'(lv[k]));
        rc(OFF_LINE_DIRECTION, 32'(dir[k]));
        rc(OFF_LINE_POLARITY_FLIP, 32'(flp[k]));
        rc(OFF_LINE_OUTPUT_SELECT, 32'(sel[k]));
      end
    end
    // Line 3 as input, looped back onto line 0
    wr(OFF_LINE_PICK, 32'h3, RESP_OKAY);
    wr(OFF_LINE_DIRECTION, 32'h0, RESP_OKAY);
    wr(OFF_LINE_POLARITY_FLIP, 32'h0, RESP_OKAY);
    wr(OFF_LINE_PICK, 32'h0, RESP_OKAY);
    wr(OFF_LINE_DIRECTION, 32'h1, RESP_OKAY);
    wr(OFF_LINE_POLARITY_FLIP, 32'h0, RESP_OKAY);
    wr(OFF_LINE_OUTPUT_SELECT, 32'(SRC_LINE3), RESP_OKAY);
    for (int v = 0; v < 2; v++)
    begin
      ext <= {v[0], 3'h0};
      repeat (30) @(posedge clk);
      chk("loop3", 32'(lout[0]), 32'(v));
    end
    // Exposure source, plain polarity
    wr(OFF_LINE_OUTPUT_SELECT, 32'(SRC_EXPOSING), RESP_OKAY);
    for (int v = 0; v < 2; v++)
    begin
      expo <= v[0];
      repeat (4) @(posedge clk);
      chk("expo", 32'(lout[0]), 32'(v));
    end
    // Trigger-wait source, inverted
    wr(OFF_LINE_POLARITY_FLIP, 32'h1, RESP_OKAY);
    wr(OFF_LINE_OUTPUT_SELECT, 32'(SRC_TRIG_WAIT), RESP_OKAY);
    for (int v = 0; v < 2; v++)
    begin
      trig <= v[0];
      repeat (4) @(posedge clk);
      chk("trig", 32'(lout[0]), 32'(!v[0]));
    end
    // Low lane off: write ignored
    wstrb <= 4'hE;
    wr(OFF_LINE_PICK, 32'h2, RESP_OKAY);
    wstrb <= 4'hF;
    rc(OFF_LINE_PICK, 32'h0);
    // Slow rail switch
    wr(OFF_AUX_RAIL_ENABLE, 32'h1, RESP_OKAY);
    rc(OFF_AUX_RAIL_ENABLE, 32'h1);
    repeat (AUX_SETTLE_CYCLES - 10) @(posedge clk);
    chk("aux_early", 32'(aux), 32'h0);
    repeat (20) @(posedge clk);
    chk("aux_late", 32'(aux), 32'h1);
    results();
  end
endmodule : camera_gpio_line_control_tb_top

// >>> tb/gpio_pins_model.sv
`timescale 1ns/1ps
// ==========================================================
// Outside circuit on the connector pins
module gpio_pins_model
(
  input wire logic [3:0] line_out_i,
  input wire logic [3:0] line_oe_i,
  input wire logic [3:0] ext_level_i,
  output logic [3:0] line_in_o
);
  // static levels, read by polling
  // Pin follows the device when enabled, else outside level
  assign line_in_o = (line_out_i & line_oe_i) |
    (ext_level_i & ~line_oe_i);
endmodule : gpio_pins_model
